// ---- bench/lsd_ctrl_model.sv ----
// controller model driving the serial pins of the led sink driver
// assumes a free running ref_clk_i; pins change 1 ns after its rising edge
`timescale 1ns/1ps
module lsd_ctrl_model (
  input wire logic ref_clk_i,
  output logic serial_clk_o,
  output logic serial_in_o,
  output logic strobe_o,
  output logic blank_n_o
);
  initial begin
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
    strobe_o = 1'b0;
    blank_n_o = 1'b1;
  end
  // ====================
  // pin sequences
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : wait_n
  // at least six ref cycles a level, well above the minimum width
  task automatic send_bit(input logic d, input logic bl);
    wait_n(1);
    serial_in_o = d;
    blank_n_o = bl;
    wait_n(6);
    serial_clk_o = 1'b1;
    wait_n(6);
    serial_clk_o = 1'b0;
    // hold is over, so the line must not keep the bit
    serial_in_o = ~d;
  endtask : send_bit
  task automatic pulse_strobe();
    wait_n(1);
    strobe_o = 1'b1;
    wait_n(8);
    strobe_o = 1'b0;
    wait_n(8);
  endtask : pulse_strobe
  task automatic set_blank(input logic bl);
    wait_n(1);
    blank_n_o = bl;
    wait_n(8);
  endtask : set_blank
  task automatic switch_mode(input logic sel, input int edges);
    send_bit(1'b0, 1'b0);
    send_bit(1'b1, 1'b1);
    send_bit(1'b0, 1'b0);
    strobe_o = sel;
    repeat (edges) send_bit(1'b1, 1'b0);
    strobe_o = 1'b0;
    wait_n(8);
  endtask : switch_mode
endmodule : lsd_ctrl_model

// ---- bench/lsd_top_tb_top.sv ----
// self-checking bench of the led sink driver serial control
// assumes lsd_ctrl_model drives the pins; faults come from the bench
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module lsd_top_tb_top;
  localparam int SW_EDGES = 2;
  logic ref_clk;
  logic resetn;
  logic sclk, serial_in, strobe, blank_n, err_act, serial_out;
  logic [15:0] fault, sink, gain, a, b, c, e, f;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  lsd_top #(.CHANNELS(16), .SWITCH_EDGES(SW_EDGES)) u_lsd_top (
    .ref_clk_i(ref_clk), .resetn_i(resetn), .serial_clk_i(sclk), .serial_in_i(serial_in),
    .strobe_mode_config_pin_i(strobe), .blank_switch_detect_pin_n_i(blank_n),
    .led_fault_i(fault), .sink_channels_o(sink), .channel_gain_o(gain),
    .error_detect_active_o(err_act), .serial_out_o(serial_out));
  lsd_ctrl_model u_lsd_ctrl_model (.ref_clk_i(ref_clk), .serial_clk_o(sclk), .serial_in_o(serial_in),
    .strobe_o(strobe), .blank_n_o(blank_n));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ====================
  // helpers
  function automatic logic [15:0] exp_sink(input logic [15:0] latch, input logic bl);
    return bl ? 16'h0 : latch;
  endfunction : exp_sink
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // msb first, so word bit i ends in stage i; checks bits leaving against prev
  task automatic shift_word(input logic [15:0] w, input logic chk, input logic [15:0] prev);
    for (int i = 15; i >= 0; i--) begin
      if (chk) `CHK(serial_out, prev[i])
      u_lsd_ctrl_model.send_bit(w[i], 1'b0);
    end
  endtask : shift_word
  // a hang would otherwise never reach the verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      results();
    end
  end
  // ====================
  // sequence
  initial begin
    resetn = 1'b0;
    fault = 16'h0;
    void'($urandom(23));
    a = $urandom;
    b = ~a; // every stage toggles
    c = $urandom;
    e = $urandom;
    f = $urandom;
    repeat (5) @(posedge ref_clk);
    #1 resetn = 1'b1;
    `CHK({sink, gain, err_act, serial_out}, 34'h0)
    shift_word(a, 1'b1, 16'h0);
    `CHK(sink, 16'h0)
    u_lsd_ctrl_model.pulse_strobe();
    `CHK(sink, exp_sink(a, 1'b0))
    shift_word(b, 1'b1, a);
    `CHK(sink, a)
    u_lsd_ctrl_model.set_blank(1'b1);
    `CHK(sink, exp_sink(a, 1'b1))
    u_lsd_ctrl_model.switch_mode(1'b1, SW_EDGES);
    `CHK(sink, a)
    shift_word(c, 1'b0, 16'h0);
    u_lsd_ctrl_model.pulse_strobe();
    `CHK(gain, c)
    `CHK(sink, a)
    fault = f;
    u_lsd_ctrl_model.send_bit(1'b0, 1'b1);
    u_lsd_ctrl_model.send_bit(1'b0, 1'b1);
    `CHK(err_act, 1'b0)
    `CHK(sink, 16'h0)
    u_lsd_ctrl_model.send_bit(1'b0, 1'b0);
    `CHK(err_act, 1'b1)
    shift_word(e, 1'b1, f);
    u_lsd_ctrl_model.switch_mode(1'b0, SW_EDGES);
    `CHK(err_act, 1'b0)
    shift_word(e, 1'b0, 16'h0);
    u_lsd_ctrl_model.pulse_strobe();
    `CHK(sink, e)
    `CHK(gain, c)
    results();
  end
endmodule : lsd_top_tb_top

// ---- rtl/lsd_pkg.sv ----
// types of the led sink driver serial control
// assumes nothing of its surroundings
package lsd_pkg;
  typedef enum logic [1:0] {
    LSD_NORMAL,
    LSD_SWITCHING,
    LSD_SPECIAL
  } lsd_mode_t;
endpackage : lsd_pkg

// ---- rtl/lsd_regs.svh ----
// constants of the led sink driver serial control
// assumes inclusion by bare name from the rtl folder
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH
// reset values
`define LSD_LATCH_RST 1'b0
`define LSD_CNT_RST 2'h0
// blank pin idles high; history starts there so reset fakes no low level
`define LSD_BLANK_IDLE 1'b1
// sync chain depth is fixed at two stages
`define LSD_SYNC_STAGES 2
// serial clock edges the switching phase lasts
`define LSD_SWITCH_EDGES 2
`endif

// ---- rtl/lsd_shift.sv ----
// serial shift register with parallel load
// assumes shift_en and load_en are one-cycle pulses on clk_i
`timescale 1ns/1ps
module lsd_shift #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic shift_en_i,
  input wire logic load_en_i,
  input wire logic serial_in_i,
  input wire logic [WIDTH-1:0] load_data_i,
  output logic [WIDTH-1:0] q_o,
  output logic serial_out_o
);
  initial begin
    if (WIDTH < 2) begin
      $error("lsd_shift: WIDTH must be at least 2");
    end
  end

  wire logic [WIDTH-1:0] shifted = {q_o[WIDTH-2:0], serial_in_i};

  // load wins over shift: detection replaces the contents
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_o <= '0;
    end else if (load_en_i) begin
      q_o <= load_data_i;
    end else if (shift_en_i) begin
      q_o <= shifted;
    end
  end

  assign serial_out_o = q_o[WIDTH-1];
endmodule : lsd_shift

// ---- rtl/lsd_top.sv ----
// serial control of a sixteen channel led sink driver
// assumes all pins are asynchronous to ref_clk_i and the serial clock is far slower
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_top #(
  parameter int CHANNELS = 16,
  parameter int SWITCH_EDGES = `LSD_SWITCH_EDGES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  input wire logic strobe_mode_config_pin_i,
  input wire logic blank_switch_detect_pin_n_i,
  input wire logic [CHANNELS-1:0] led_fault_i,
  output logic [CHANNELS-1:0] sink_channels_o,
  output logic [CHANNELS-1:0] channel_gain_o,
  output logic error_detect_active_o,
  output logic serial_out_o
);
  localparam int PW = CHANNELS + 4;
  localparam logic [PW-1:0] PIN_IDLE = {{(PW-1){1'b0}}, `LSD_BLANK_IDLE};

  initial begin
    if (CHANNELS != 16) begin
      $error("lsd_top: CHANNELS must be 16");
    end
    if (SWITCH_EDGES < 1 || SWITCH_EDGES > 3) begin
      $error("lsd_top: SWITCH_EDGES must be 1 to 3");
    end
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  wire logic [PW-1:0] pin_raw = {led_fault_i, serial_clk_i, serial_in_i,
                                 strobe_mode_config_pin_i, blank_switch_detect_pin_n_i};

  // all pins share one chain so data stays aligned with the serial clock
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire logic [CHANNELS-1:0] fault_s = pin_sync[PW-1:4];
  wire logic sclk_s = pin_sync[3];
  wire logic sdi_s = pin_sync[2];
  wire logic strobe_s = pin_sync[1];
  wire logic blank_n_s = pin_sync[0];

  logic sclk_d;
  logic strobe_d;
  logic edge_blank1;
  logic edge_blank2;

  wire logic sclk_rise = sclk_s & ~sclk_d;
  wire logic strobe_rise = strobe_s & ~strobe_d;

  // blank level history sampled at serial clock edges
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_d <= `LSD_LATCH_RST;
      strobe_d <= `LSD_LATCH_RST;
      edge_blank1 <= `LSD_BLANK_IDLE;
      edge_blank2 <= `LSD_BLANK_IDLE;
    end else begin
      sclk_d <= sclk_s;
      strobe_d <= strobe_s;
      if (sclk_rise) begin
        edge_blank1 <= blank_n_s;
        edge_blank2 <= edge_blank1;
      end
    end
  end

  // ==========================================================
  // mode sequencing
  // ==========================================================
  lsd_pkg::lsd_mode_t mode;
  lsd_pkg::lsd_mode_t next_mode;
  logic [1:0] sw_cnt;
  logic [1:0] next_sw_cnt;
  logic sw_sel;
  logic next_sw_sel;

  // low, high, low at three successive edges is a one-period pulse
  wire logic trigger = sclk_rise & ~blank_n_s & edge_blank1 & ~edge_blank2;
  wire logic sw_last = (sw_cnt == 2'(SWITCH_EDGES - 1));
  wire logic sel_now = sw_sel | strobe_s;
  wire logic in_normal = (mode == lsd_pkg::LSD_NORMAL);
  wire logic in_special = (mode == lsd_pkg::LSD_SPECIAL);
  wire logic in_switch = (mode == lsd_pkg::LSD_SWITCHING);

  always_comb begin
    next_mode = mode;
    next_sw_cnt = sw_cnt;
    next_sw_sel = sw_sel;
    unique case (mode)
      lsd_pkg::LSD_NORMAL,
      lsd_pkg::LSD_SPECIAL: begin
        next_sw_cnt = `LSD_CNT_RST;
        next_sw_sel = `LSD_LATCH_RST;
      end
      lsd_pkg::LSD_SWITCHING: begin
        // a strobe pulse anywhere in the phase counts as a high level
        next_sw_sel = sel_now;
        if (sclk_rise && sw_last) begin
          next_mode = sel_now ? lsd_pkg::LSD_SPECIAL : lsd_pkg::LSD_NORMAL;
        end else if (sclk_rise) begin
          next_sw_cnt = sw_cnt + 2'h1;
        end
      end
    endcase
    if (trigger) begin
      next_mode = lsd_pkg::LSD_SWITCHING;
      next_sw_cnt = `LSD_CNT_RST;
      next_sw_sel = `LSD_LATCH_RST;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= lsd_pkg::LSD_NORMAL;
      sw_cnt <= `LSD_CNT_RST;
      sw_sel <= `LSD_LATCH_RST;
    end else begin
      mode <= next_mode;
      sw_cnt <= next_sw_cnt;
      sw_sel <= next_sw_sel;
    end
  end

  // ==========================================================
  // shift register and detection
  // ==========================================================
  logic [CHANNELS-1:0] sr_q;

  // first low edge of a special mode blank period captures the faults
  wire logic detect_load = sclk_rise & in_special & ~blank_n_s & edge_blank1;
  wire logic shift_en = sclk_rise & ~detect_load;

  lsd_shift #(
    .WIDTH(CHANNELS)
  ) u_shift (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .shift_en_i(shift_en),
    .load_en_i(detect_load),
    .serial_in_i(sdi_s),
    .load_data_i(fault_s),
    .q_o(sr_q),
    .serial_out_o(serial_out_o)
  );

  // ==========================================================
  // latches and outputs
  // ==========================================================
  logic [CHANNELS-1:0] out_latch;
  logic [CHANNELS-1:0] config_latch;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_latch <= '0;
      config_latch <= '0;
      sink_channels_o <= '0;
      error_detect_active_o <= `LSD_LATCH_RST;
    end else begin
      if (in_normal && strobe_s) begin
        out_latch <= sr_q;
      end
      if (in_special && strobe_rise) begin
        config_latch <= sr_q;
      end
      sink_channels_o <= out_latch & {CHANNELS{~blank_n_s}};
      error_detect_active_o <= in_special & ~blank_n_s;
    end
  end

  // one shared code, the analog side scales every channel alike
  assign channel_gain_o = config_latch;

  // ==========================================================
  // checks
  // ==========================================================
  property p_shift;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift_en |=> sr_q == {$past(sr_q[CHANNELS-2:0]), $past(sdi_s)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not take serial input");

  property p_follow;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    in_normal && strobe_s |=> out_latch == $past(sr_q);
  endproperty
  a_follow: assert property (p_follow) else $error("output latch not transparent");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !(in_normal && strobe_s) |=> $stable(out_latch);
  endproperty
  a_hold: assert property (p_hold) else $error("output latch changed without strobe");

  property p_sink;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    1'b1 |=> sink_channels_o == ($past(out_latch) & {CHANNELS{~$past(blank_n_s)}});
  endproperty
  a_sink: assert property (p_sink) else $error("sink outputs disagree with latch and blank");

  property p_cfg_load;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    in_special && strobe_rise |=> channel_gain_o == $past(sr_q);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("configuration latch not loaded");

  property p_cfg_switch;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    in_switch |=> $stable(config_latch);
  endproperty
  a_cfg_switch: assert property (p_cfg_switch) else $error("strobe latched data while switching");

  property p_trigger;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    trigger |=> in_switch && sw_cnt == `LSD_CNT_RST;
  endproperty
  a_trigger: assert property (p_trigger) else $error("switch pulse not recognised");

  property p_adopt;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    in_switch && sclk_rise && sw_last && !trigger |=>
      mode == ($past(sel_now) ? lsd_pkg::LSD_SPECIAL : lsd_pkg::LSD_NORMAL);
  endproperty
  a_adopt: assert property (p_adopt) else $error("wrong mode adopted");

  property p_persist;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !in_switch && !trigger |=> $stable(mode);
  endproperty
  a_persist: assert property (p_persist) else $error("mode changed without switch");

  property p_detect;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    detect_load |=> sr_q == $past(fault_s) && error_detect_active_o;
  endproperty
  a_detect: assert property (p_detect) else $error("fault status not loaded");

  property p_sdo;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift_en |=> serial_out_o == $past(sr_q[CHANNELS-2]);
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial output not last stage");
endmodule : lsd_top
